// ### core_state_regs.sv
// Contract
// - Clear global enable blocks every interrupt
// - Global enable: take clears, return/set sets
// - Status never saved or restored automatically
// - Bit 6 copies register bits both ways
// - Bit 5 records low nibble carry
// - Sign bit always negative xor overflow
// - Bit 2 negative, bit 1 zero
// - Bit 0 carry, bit 3 overflow
// - Flags updated after every ALU operation
// - Byte and word read/write port patterns
// - Registers mapped at data addresses 0-31
// - Top six registers form three pointers
// - Page register bits 7..1 read zero
// - Page bit selects program memory half
// - Plain program load ignores page bit
// - Data push/pop moves pointer by one
// - Call/return moves pointer by two
// - Stack pointer two bytes, reset zero
// - Core runs undivided on its clock
// - Fetch overlaps execute every cycle
// - Read, compute, write back in one cycle
`timescale 1ns/10ps
`default_nettype none
module core_state_regs (
    input wire logic i_clk,                                  // Core clock
    input wire logic i_resetn,                               // Sync reset, low
    input wire logic [7:0] i_address,                        // Avalon byte address
    input wire logic i_read,                                 // Avalon read
    input wire logic i_write,                                // Avalon write
    input wire logic [3:0] i_byteenable,                     // Avalon byte lanes
    input wire logic [31:0] i_writedata,                     // Avalon write data
    output logic [31:0] o_readdata,                          // Avalon read data
    output logic o_waitrequest,                              // Avalon wait
    input wire logic [4:0] i_rd_a_idx,                       // Operand A index
    input wire logic [4:0] i_rd_b_idx,                       // Operand B index
    input wire logic [3:0] i_rd_w_pair,                      // Word operand pair
    output logic [7:0] o_rd_a,                               // Operand A
    output logic [7:0] o_rd_b,                               // Operand B
    output logic [15:0] o_rd_w,                              // Word operand
    input wire core_state_pkg::byte_wr_t i_byte_wr,          // 8-bit result
    input wire core_state_pkg::word_wr_t i_word_wr,          // 16-bit result
    input wire logic i_alu_update,                           // ALU op done
    input wire core_state_pkg::alu_flags_t i_alu_flags,      // New flag values
    input wire core_state_pkg::alu_flags_t i_alu_mask,       // Flags the op defines
    input wire logic i_bit_store_op,                         // Register bit to T
    input wire logic i_bit_load_op,                          // T to register bit
    input wire logic [4:0] i_bit_reg,                        // Bit op register
    input wire logic [2:0] i_bit_pos,                        // Bit op position
    input wire logic i_irq_req,                              // Pending interrupt
    output logic o_irq_grant,                                // Interrupt may go
    input wire logic i_irq_take,                             // Interrupt taken
    input wire logic i_return_from_interrupt,                // Return from irq
    input wire logic i_set_global,                           // Set-enable op
    input wire logic i_clear_global,                         // Clear-enable op
    input wire core_state_pkg::stack_op_t i_stack_op,        // Stack pointer op
    output logic [15:0] o_stack_pointer,                     // Stack pointer
    input wire logic i_ptr_en,                               // Pointer access
    input wire core_state_pkg::ptr_sel_t i_ptr_sel,          // X, Y or Z
    input wire core_state_pkg::ptr_mode_t i_ptr_mode,        // Addressing mode
    input wire logic [5:0] i_ptr_disp,                       // Displacement
    output logic [15:0] o_ptr_addr,                          // Effective address
    input wire logic [15:0] i_ds_addr,                       // Data-space address
    input wire logic i_ds_write,                             // Data-space write
    input wire logic [7:0] i_ds_wdata,                       // Data-space data
    output logic o_ds_hit,                                   // Address in file
    output logic [7:0] o_ds_rdata,                           // Data-space read
    input wire logic i_plain_program_load,                   // Plain load
    input wire logic i_extended_program_load,                // Extended load/store
    output logic [16:0] o_prog_addr,                         // Program byte addr
    input wire logic i_fetch_valid,                          // Fetch word valid
    input wire logic [15:0] i_fetch_word,                    // Fetched word
    output logic [15:0] o_instr,                             // Executing word
    output core_state_pkg::status_t o_status,                // Status flags
    output logic o_program_half_select                       // Page bit
);
    logic [7:0] gpr [core_state_pkg::NUM_REGS];
    core_state_pkg::status_t status;
    core_state_pkg::status_t next_status;
    logic [7:0] page;
    logic [15:0] stack_pointer;
    logic [15:0] next_stack_pointer;
    logic ack;
    logic bus_wr;
    logic gpr_bus_hit;
    logic [15:0] ptr_base;
    logic [15:0] ptr_wb;
    logic ptr_wb_en;
    logic [3:0] ptr_pair;

    function automatic logic [15:0] pair_value(input logic [3:0] pair);
        pair_value = {gpr[{pair, 1'b1}], gpr[{pair, 1'b0}]};
    endfunction : pair_value

    function automatic logic [3:0] sel_pair(input core_state_pkg::ptr_sel_t sel);
        unique case (sel)
            core_state_pkg::SEL_X: sel_pair = core_state_pkg::PAIR_X;
            core_state_pkg::SEL_Y: sel_pair = core_state_pkg::PAIR_Y;
            default: sel_pair = core_state_pkg::PAIR_Z;
        endcase
    endfunction : sel_pair

    function automatic logic is_gpr_addr(input logic [7:0] addr);
        is_gpr_addr = (addr[7] == core_state_pkg::OFS_GPR_BASE[7]) && (addr[1:0] == 2'h0);
    endfunction : is_gpr_addr

    // Avalon slave: one wait cycle, then the answer
    assign o_waitrequest = (i_read | i_write) & ~ack;
    assign bus_wr = i_write & ack & i_byteenable[0];
    assign gpr_bus_hit = is_gpr_addr(i_address);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ack <= 1'b0;
        end else begin
            ack <= (i_read | i_write) & ~ack;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_readdata <= 32'h0000_0000;
        end else if (i_read && !ack) begin
            o_readdata <= 32'h0000_0000;
            if (gpr_bus_hit) begin
                o_readdata[7:0] <= gpr[i_address[6:2]];
            end else begin
                unique case (i_address)
                    core_state_pkg::OFS_STATUS: o_readdata[7:0] <= status;
                    core_state_pkg::OFS_PAGE: o_readdata[7:0] <= page;
                    core_state_pkg::OFS_SP_LOW: o_readdata[7:0] <= stack_pointer[7:0];
                    core_state_pkg::OFS_SP_HIGH: o_readdata[7:0] <= stack_pointer[15:8];
                    default: o_readdata[7:0] <= 8'h00;
                endcase
            end
        end
    end

    // Status register: later terms take priority, bus write last
    always_comb begin
        next_status = status;
        if (i_alu_update) begin
            if (i_alu_mask.h) next_status.h = i_alu_flags.h;
            if (i_alu_mask.v) next_status.v = i_alu_flags.v;
            if (i_alu_mask.c) next_status.c = i_alu_flags.c;
            if (i_alu_mask.n) next_status.n = i_alu_flags.n;
            if (i_alu_mask.z) next_status.z = i_alu_flags.z;
        end
        if (i_bit_store_op) begin
            next_status.t = gpr[i_bit_reg][i_bit_pos];
        end
        // No save or restore of the flags on entry or return
        if (i_set_global || i_return_from_interrupt) begin
            next_status.i = 1'b1;
        end
        if (i_clear_global || i_irq_take) begin
            next_status.i = 1'b0;
        end
        if (bus_wr && !gpr_bus_hit && i_address == core_state_pkg::OFS_STATUS) begin
            next_status = i_writedata[7:0];
        end
        // Sign is never stored independently, so it cannot drift
        next_status.s = next_status.n ^ next_status.v;
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            status <= core_state_pkg::STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // Global gate: individual enables are outside this block
    assign o_irq_grant = i_irq_req & status.i;
    assign o_status = status;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            page <= core_state_pkg::PAGE_RESET;
        end else if (bus_wr && !gpr_bus_hit && i_address == core_state_pkg::OFS_PAGE) begin
            page <= i_writedata[7:0] & core_state_pkg::PAGE_WRITE_MASK;
        end
    end
    assign o_program_half_select = page[core_state_pkg::BIT_PAGE_HALF];

    always_comb begin
        if (i_extended_program_load && !i_plain_program_load) begin
            o_prog_addr = {page[core_state_pkg::BIT_PAGE_HALF], pair_value(core_state_pkg::PAIR_Z)};
        end else begin
            o_prog_addr = {1'b0, pair_value(core_state_pkg::PAIR_Z)};
        end
    end

    // Stack pointer, plain modulo arithmetic on all sixteen bits
    always_comb begin
        next_stack_pointer = stack_pointer;
        unique case (i_stack_op)
            core_state_pkg::STK_PUSH1: next_stack_pointer = stack_pointer - core_state_pkg::STEP_ONE;
            core_state_pkg::STK_POP1: next_stack_pointer = stack_pointer + core_state_pkg::STEP_ONE;
            core_state_pkg::STK_PUSH2: next_stack_pointer = stack_pointer - core_state_pkg::STEP_TWO;
            core_state_pkg::STK_POP2: next_stack_pointer = stack_pointer + core_state_pkg::STEP_TWO;
            default: next_stack_pointer = stack_pointer;
        endcase
        if (bus_wr && !gpr_bus_hit && i_address == core_state_pkg::OFS_SP_LOW) begin
            next_stack_pointer[7:0] = i_writedata[7:0];
        end
        if (bus_wr && !gpr_bus_hit && i_address == core_state_pkg::OFS_SP_HIGH) begin
            next_stack_pointer[15:8] = i_writedata[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            stack_pointer <= core_state_pkg::SP_RESET;
        end else begin
            stack_pointer <= next_stack_pointer;
        end
    end
    assign o_stack_pointer = stack_pointer;

    // Pointer addressing; the update is written back in the same cycle
    assign ptr_pair = sel_pair(i_ptr_sel);
    assign ptr_base = pair_value(ptr_pair);
    always_comb begin
        o_ptr_addr = ptr_base;
        ptr_wb = ptr_base;
        ptr_wb_en = 1'b0;
        unique case (i_ptr_mode)
            core_state_pkg::PTR_DISP: o_ptr_addr = ptr_base + {10'h000, i_ptr_disp};
            core_state_pkg::PTR_POSTINC: begin
                ptr_wb = ptr_base + core_state_pkg::STEP_ONE;
                ptr_wb_en = i_ptr_en;
            end
            core_state_pkg::PTR_PREDEC: begin
                o_ptr_addr = ptr_base - core_state_pkg::STEP_ONE;
                ptr_wb = ptr_base - core_state_pkg::STEP_ONE;
                ptr_wb_en = i_ptr_en;
            end
            default: o_ptr_addr = ptr_base;
        endcase
    end

    // Low data space aliases the register file
    assign o_ds_hit = i_ds_addr < core_state_pkg::DS_REG_LIMIT;
    assign o_ds_rdata = o_ds_hit ? gpr[i_ds_addr[4:0]] : 8'h00;

    // Combinational reads let an op read, compute and write in one cycle
    assign o_rd_a = gpr[i_rd_a_idx];
    assign o_rd_b = gpr[i_rd_b_idx];
    assign o_rd_w = pair_value(i_rd_w_pair);

    // Writers in rising priority; a result beats a pointer update
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            for (int k = 0; k < core_state_pkg::NUM_REGS; k++) begin
                gpr[k] <= 8'h00;
            end
        end else begin
            if (ptr_wb_en) begin
                gpr[{ptr_pair, 1'b0}] <= ptr_wb[7:0];
                gpr[{ptr_pair, 1'b1}] <= ptr_wb[15:8];
            end
            if (i_bit_load_op) begin
                gpr[i_bit_reg][i_bit_pos] <= status.t;
            end
            if (i_byte_wr.en) begin
                gpr[i_byte_wr.idx] <= i_byte_wr.data;
            end
            if (i_word_wr.en) begin
                gpr[{i_word_wr.pair, 1'b0}] <= i_word_wr.data[7:0];
                gpr[{i_word_wr.pair, 1'b1}] <= i_word_wr.data[15:8];
            end
            if (i_ds_write && o_ds_hit) begin
                gpr[i_ds_addr[4:0]] <= i_ds_wdata;
            end
            if (bus_wr && gpr_bus_hit) begin
                gpr[i_address[6:2]] <= i_writedata[7:0];
            end
        end
    end

    // Next word is captured while the current one executes
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_instr <= 16'h0000;
        end else if (i_fetch_valid) begin
            o_instr <= i_fetch_word;
        end
    end

    logic status_bus_wr;
    logic sp_bus_wr;
    assign status_bus_wr = bus_wr && !gpr_bus_hit && i_address == core_state_pkg::OFS_STATUS;
    assign sp_bus_wr = bus_wr && !gpr_bus_hit &&
        (i_address == core_state_pkg::OFS_SP_LOW || i_address == core_state_pkg::OFS_SP_HIGH);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    irq_gate_a: assert property (o_irq_grant |-> status.i && i_irq_req) else $error("grant while disabled");
    irq_clear_a: assert property (i_irq_take && !status_bus_wr |=> !status.i)
        else $error("take left enable set");
    return_from_interrupt_set_a: assert property (i_return_from_interrupt && !i_irq_take && !i_clear_global && !status_bus_wr
        |=> status.i) else $error("return left enable clear");
    sign_xor_a: assert property (status.s == (status.n ^ status.v)) else $error("sign mismatch");
    bit_store_a: assert property (i_bit_store_op && !status_bus_wr |=> status.t == $past(gpr[i_bit_reg][i_bit_pos]))
        else $error("bit store wrong");
    flag_update_a: assert property (i_alu_update && i_alu_mask.z && !status_bus_wr |=> status.z == $past(i_alu_flags.z))
        else $error("zero flag not updated");
    push_one_a: assert property (i_stack_op == core_state_pkg::STK_PUSH1 && !sp_bus_wr
        |=> stack_pointer == $past(stack_pointer) - core_state_pkg::STEP_ONE) else $error("push step");
    pop_two_a: assert property (i_stack_op == core_state_pkg::STK_POP2 && !sp_bus_wr
        |=> stack_pointer == $past(stack_pointer) + core_state_pkg::STEP_TWO) else $error("return step");
    page_reserved_a: assert property (page[7:1] == 7'h00) else $error("reserved page bits set");
    plain_load_a: assert property (i_plain_program_load || !i_extended_program_load |-> o_prog_addr[16] == 1'b0)
        else $error("plain load used page");
    ext_load_a: assert property (i_extended_program_load && !i_plain_program_load |-> o_prog_addr[16] == page[0])
        else $error("extended load half wrong");
    bus_answer_a: assert property ((i_read || i_write) && !ack |=> !o_waitrequest)
        else $error("bus answer late");
    result_write_a: assert property (i_byte_wr.en && !(bus_wr && gpr_bus_hit) && !(i_ds_write && o_ds_hit)
        && !(i_word_wr.en && i_word_wr.pair == i_byte_wr.idx[4:1])
        |=> gpr[$past(i_byte_wr.idx)] == $past(i_byte_wr.data)) else $error("result not written");
endmodule : core_state_regs
`default_nettype wire

// ### core_state_pkg.sv
`default_nettype none
package core_state_pkg;
    localparam int NUM_REGS = 32;
    localparam int REG_IDX_W = 5;
    localparam int PAIR_IDX_W = 4;
    localparam int BUS_ADDR_W = 8;

    // Bus byte offsets, one 32-bit word per register
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_PAGE = 8'h04;
    localparam logic [7:0] OFS_SP_LOW = 8'h08;
    localparam logic [7:0] OFS_SP_HIGH = 8'h0C;
    localparam logic [7:0] OFS_GPR_BASE = 8'h80;

    // Status bit positions
    localparam int BIT_I = 7;
    localparam int BIT_T = 6;
    localparam int BIT_H = 5;
    localparam int BIT_S = 4;
    localparam int BIT_V = 3;
    localparam int BIT_N = 2;
    localparam int BIT_Z = 1;
    localparam int BIT_C = 0;
    localparam int BIT_PAGE_HALF = 0;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] PAGE_WRITE_MASK = 8'h01;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;

    // Pair index of the pointer pairs (register number / 2)
    localparam logic [3:0] PAIR_X = 4'hD;
    localparam logic [3:0] PAIR_Y = 4'hE;
    localparam logic [3:0] PAIR_Z = 4'hF;
    localparam logic [15:0] DS_REG_LIMIT = 16'h0020;

    typedef enum logic [4:0] {
        STK_NONE = 5'b00001,
        STK_PUSH1 = 5'b00010,
        STK_POP1 = 5'b00100,
        STK_PUSH2 = 5'b01000,
        STK_POP2 = 5'b10000
    } stack_op_t;

    typedef enum logic [2:0] {
        PTR_DISP = 3'b001,
        PTR_POSTINC = 3'b010,
        PTR_PREDEC = 3'b100
    } ptr_mode_t;

    typedef enum logic [1:0] {
        SEL_X = 2'h0,
        SEL_Y = 2'h1,
        SEL_Z = 2'h2
    } ptr_sel_t;

    typedef struct packed {
        logic i;
        logic t;
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } status_t;

    typedef struct packed {
        logic h;
        logic v;
        logic n;
        logic z;
        logic c;
    } alu_flags_t;

    typedef struct packed {
        logic en;
        logic [4:0] idx;
        logic [7:0] data;
    } byte_wr_t;

    typedef struct packed {
        logic en;
        logic [3:0] pair;
        logic [15:0] data;
    } word_wr_t;
endpackage : core_state_pkg
`default_nettype wire

// ### irq_sequencer_model.sv
`timescale 1ns/10ps
`default_nettype none
module irq_sequencer_model (
    input wire logic i_clk,    // Core clock
    input wire logic i_resetn, // Sync reset, low
    input wire logic i_grant,  // Interrupt may go
    input wire logic i_enable, // Sequencer active
    output logic o_take        // Take pulse
);
    // Gap after each take, so the cleared enable is seen before another grant
    always_ff @(posedge i_clk) begin
        o_take <= i_resetn & i_enable & i_grant & ~o_take;
    end
endmodule : irq_sequencer_model
`default_nettype wire

// ### tb_cpu_core_state_registers.sv
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_core_state_registers;
    logic clk = 0, resetn = 0, rd = 0, wr = 0, alu_up = 0, bit_st = 0, bit_ld = 0, irq_req = 0, irq_en = 0;
    logic irq_ret = 0, set_gie = 0, clr_gie = 0, ptr_en = 0, ds_we = 0, plain_ld = 0, ext_ld = 0, fv = 0;
    logic take, grant, wreq, hit, half;
    logic [3:0] be = 4'h1, w_pair = 4'h0;
    logic [4:0] a_idx = 5'h00, b_idx = 5'h00, bit_reg = 5'h00;
    logic [2:0] bit_pos = 3'h0;
    logic [5:0] disp = 6'h05;
    logic [7:0] addr = 8'h00, ds_d = 8'h00, ra, rb, ds_q;
    logic [15:0] ds_a = 16'h0000, fw = 16'h0000, rw, stk_ptr, paddr, instr;
    logic [16:0] prog;
    logic [31:0] wd = 32'h0, rdata, q;
    core_state_pkg::alu_flags_t fl = '0, fm = '0;
    core_state_pkg::byte_wr_t bw = '0;
    core_state_pkg::word_wr_t ww = '0;
    core_state_pkg::stack_op_t sop = core_state_pkg::STK_NONE;
    core_state_pkg::ptr_mode_t pm = core_state_pkg::PTR_DISP;
    core_state_pkg::ptr_sel_t ps = core_state_pkg::SEL_Z;
    core_state_pkg::status_t st;
    int fails = 0, comparisons = 0, cycles = 0;

    core_state_regs core_state_regs_i (.i_clk(clk), .i_resetn(resetn), .i_address(addr), .i_read(rd),
        .i_write(wr), .i_byteenable(be), .i_writedata(wd), .o_readdata(rdata), .o_waitrequest(wreq),
        .i_rd_a_idx(a_idx), .i_rd_b_idx(b_idx), .i_rd_w_pair(w_pair), .o_rd_a(ra), .o_rd_b(rb), .o_rd_w(rw),
        .i_byte_wr(bw), .i_word_wr(ww), .i_alu_update(alu_up), .i_alu_flags(fl), .i_alu_mask(fm),
        .i_bit_store_op(bit_st), .i_bit_load_op(bit_ld), .i_bit_reg(bit_reg), .i_bit_pos(bit_pos),
        .i_irq_req(irq_req), .o_irq_grant(grant), .i_irq_take(take), .i_return_from_interrupt(irq_ret),
        .i_set_global(set_gie), .i_clear_global(clr_gie), .i_stack_op(sop), .o_stack_pointer(stk_ptr),
        .i_ptr_en(ptr_en), .i_ptr_sel(ps), .i_ptr_mode(pm), .i_ptr_disp(disp), .o_ptr_addr(paddr),
        .i_ds_addr(ds_a), .i_ds_write(ds_we), .i_ds_wdata(ds_d), .o_ds_hit(hit), .o_ds_rdata(ds_q),
        .i_plain_program_load(plain_ld), .i_extended_program_load(ext_ld), .o_prog_addr(prog),
        .i_fetch_valid(fv), .i_fetch_word(fw), .o_instr(instr), .o_status(st), .o_program_half_select(half));
    irq_sequencer_model irq_sequencer_model_i (.i_clk(clk), .i_resetn(resetn), .i_grant(grant),
        .i_enable(irq_en), .o_take(take));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // Waitrequest and read data are taken at the rising edge itself, before that edge's updates land
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        logic ws;
        @(posedge clk);
        addr <= a;
        wd <= {24'h0, d};
        rd <= ~w;
        wr <= w;
        do begin
            @(posedge clk);
            ws = wreq;
            q = rdata;
        end while (ws !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    // Ends every core pulse after one taken edge
    task automatic settle;
        @(posedge clk);
        {alu_up, bit_st, bit_ld, irq_ret, set_gie, clr_gie, ptr_en, ds_we, fv, ext_ld, plain_ld} <= '0;
        bw <= '0;
        ww <= '0;
        sop <= core_state_pkg::STK_NONE;
        @(negedge clk);
    endtask : settle

    task automatic stk(input core_state_pkg::stack_op_t o, input logic [15:0] e);
        @(posedge clk);
        sop <= o;
        settle();
        chk("stack_ptr", {16'h0, e}, {16'h0, stk_ptr});
    endtask : stk

    task automatic alu(input logic [4:0] f, input logic [4:0] m, input logic [7:0] e);
        @(posedge clk);
        alu_up <= 1'b1;
        fl <= f;
        fm <= m;
        settle();
        chk("status", {24'h0, e}, {24'h0, st});
    endtask : alu

    task automatic ptr(input core_state_pkg::ptr_mode_t m, input logic [15:0] ea, input logic [15:0] ez);
        @(posedge clk);
        ptr_en <= 1'b1;
        pm <= m;
        @(negedge clk);
        chk("ptr_addr", {16'h0, ea}, {16'h0, paddr});
        settle();
        chk("pointer", {16'h0, ez}, {16'h0, rw});
    endtask : ptr

    task automatic t_reset;
        logic [7:0] ofs [5];
        ofs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h40};
        @(posedge clk);
        be <= 4'h0;
        bus(1'b1, 8'h00, 8'hFF);
        be <= 4'h1;
        bus(1'b1, 8'h40, 8'hFF);
        foreach (ofs[k]) begin
            bus(1'b0, ofs[k], 8'h00);
            chk("reset_read", 32'h0, q);
        end
    endtask : t_reset

    task automatic t_regs;
        bus(1'b1, 8'h08, 8'h80);
        bus(1'b1, 8'h0C, 8'h01);
        bus(1'b0, 8'h0C, 8'h00);
        chk("sp_bytes", 32'h00010180, {q[15:0], stk_ptr});
        stk(core_state_pkg::STK_PUSH1, 16'h017F);
        stk(core_state_pkg::STK_POP1, 16'h0180);
        stk(core_state_pkg::STK_PUSH2, 16'h017E);
        stk(core_state_pkg::STK_POP2, 16'h0180);
        bus(1'b1, 8'h08, 8'h00);
        bus(1'b1, 8'h0C, 8'h00);
        stk(core_state_pkg::STK_PUSH1, 16'hFFFF);
        stk(core_state_pkg::STK_POP2, 16'h0001);
        bus(1'b1, 8'h04, 8'hFF);
        bus(1'b0, 8'h04, 8'h00);
        chk("page", 32'h00000101, {q[23:0], 7'h00, half});
    endtask : t_regs

    task automatic t_irq;
        bus(1'b1, 8'h00, 8'h40);
        @(posedge clk);
        irq_req <= 1'b1;
        irq_en <= 1'b1;
        @(negedge clk);
        chk("grant_off", 32'h0, {31'h0, grant});
        @(posedge clk);
        set_gie <= 1'b1;
        settle();
        chk("grant_on", 32'h1, {31'h0, grant});
        for (int k = 0; k < 8 && st.i !== 1'b0; k++)
            @(negedge clk);
        chk("taken", 32'h40, {24'h0, st});
        @(posedge clk);
        irq_en <= 1'b0;
        irq_ret <= 1'b1;
        settle();
        chk("returned", 32'hC0, {24'h0, st});
        @(posedge clk);
        clr_gie <= 1'b1;
        irq_req <= 1'b0;
        settle();
        chk("cleared", 32'h40, {24'h0, st});
    endtask : t_irq

    task automatic t_data;
        @(posedge clk);
        bw <= '{1'b1, 5'h03, 8'h55};
        ww <= '{1'b1, 4'h2, 16'hA1B2};
        fv <= 1'b1;
        fw <= 16'h1234;
        a_idx <= 5'h03;
        b_idx <= 5'h05;
        w_pair <= 4'h2;
        settle();
        chk("ports", 32'h55A1A1B2, {ra, rb, rw});
        chk("instr", 32'h1234, {16'h0, instr});
        @(posedge clk);
        ds_a <= 16'h001F;
        ds_d <= 8'h3C;
        ds_we <= 1'b1;
        settle();
        chk("ds_hit", 32'h13C, {23'h0, hit, ds_q});
        @(posedge clk);
        ds_a <= 16'h0020;
        bw <= '{1'b1, 5'h1E, 8'h10};
        w_pair <= 4'hF;
        settle();
        chk("ds_miss", 32'h0, {23'h0, hit, ds_q});
        bus(1'b0, 8'hFC, 8'h00);
        chk("gpr_bus", 32'h3C, q);
        ptr(core_state_pkg::PTR_POSTINC, 16'h3C10, 16'h3C11);
        ptr(core_state_pkg::PTR_PREDEC, 16'h3C10, 16'h3C10);
        ptr(core_state_pkg::PTR_DISP, 16'h3C15, 16'h3C10);
        @(posedge clk);
        ext_ld <= 1'b1;
        @(negedge clk);
        chk("ext_load", 32'h13C10, {15'h0, prog});
        settle();
        @(posedge clk);
        plain_ld <= 1'b1;
        @(negedge clk);
        chk("plain_load", 32'h03C10, {15'h0, prog});
        settle();
    endtask : t_data

    task automatic t_flags;
        alu(5'h15, 5'h1F, 8'h75);
        alu(5'h0A, 5'h02, 8'h77);
        alu(5'h08, 5'h08, 8'h6F);
        @(posedge clk);
        bit_st <= 1'b1;
        bit_reg <= 5'h03;
        bit_pos <= 3'h1;
        a_idx <= 5'h03;
        settle();
        chk("copy_bit", 32'h2F, {24'h0, st});
        @(posedge clk);
        bit_ld <= 1'b1;
        bit_pos <= 3'h0;
        settle();
        chk("load_bit", 32'h54, {24'h0, ra});
    endtask : t_flags

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_regs();
        t_irq();
        t_data();
        t_flags();
        tally_and_finish();
    end
endmodule : tb_cpu_core_state_registers
`default_nettype wire
